/* pkg/board_cmd_regs.svh */
// command codes, status bit positions, thresholds and control subcommands
`ifndef BOARD_CMD_REGS_SVH
`define BOARD_CMD_REGS_SVH

`define CODE_STATE 8'h00
`define CODE_HW_REV 8'h04
`define CODE_FW_REV 8'h06
`define CODE_ERRORS 8'h08
`define CODE_RAIL_MV 8'h0a
`define CODE_RAIL_MA 8'h0c
`define CODE_FILT_MV 8'h12
`define CODE_FILT_MA 8'h14
`define CODE_ONBOARD_C 8'h16
`define CODE_REMOTE_C 8'h18
`define CODE_CHG_ERR 8'h1a
`define CODE_CMD_PORT 8'h1c

`define BIT_FAULT 15
`define BIT_DSG_TERM 12
`define BIT_DSG_PULSE 11
`define BIT_DSG_CP 10
`define BIT_DSG_CI 9
`define BIT_CHG_TERM 8
`define BIT_CHG 7
`define BIT_REMOTE 6
`define BIT_GAUGE_SUPPLY 5
`define BIT_GAUGE_ON 4
`define BIT_SUPPLY 3
`define BIT_REFREG 2
`define BIT_UNDERV 1
`define BIT_LINKED 0

`define CUTOFF_MV 16'h0af0
`define CHG_CUTOFF_MA 16'hffff

`define SUB_STOP 16'h0000
`define SUB_CONNECT 16'h0001
`define SUB_DISCONNECT 16'h0002
`define SUB_START_CI 16'h0005
`define SUB_START_CP 16'h0006
`define SUB_START_PULSE 16'h0007
`define SUB_START_CHG 16'h0008

`define CMD_PORT_RESET 16'h0000
`endif

/* pkg/board_cmd_pkg.sv */
// types shared by the command register bank
`default_nettype none
package board_cmd_pkg;
  typedef logic [7:0] code_t;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {
    op_idle,
    op_charge,
    op_discharge
  } op_t;
  typedef enum logic [1:0] {
    mode_none,
    mode_ci,
    mode_cp,
    mode_pulse
  } dsg_mode_t;
endpackage
`default_nettype wire

/* logic/code_pointer.sv */
// command code pointer: latches the code, steps it after each data byte
`timescale 1ns/10ps
`default_nettype none
module code_pointer (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic code_load_in,
  input wire board_cmd_pkg::code_t code_in,
  input wire logic byte_done_in,
  output board_cmd_pkg::code_t code_out
);
  import board_cmd_pkg::*;
  code_t ptr;
  code_t next_ptr;

  // each data byte moves to the next code, low byte then high byte
  always_comb begin
    next_ptr = ptr;
    if (code_load_in) begin
      next_ptr = code_in;
    end else if (byte_done_in) begin
      next_ptr = ptr + 8'h01;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ptr <= 8'h00;
    end else begin
      ptr <= next_ptr;
    end
  end

  assign code_out = ptr;
endmodule
`default_nettype wire

/* logic/eval_board_command_registers.sv */
// board command/status register bank reached through byte command codes
// ==========================================================================
// Notes on behaviour
// - every command is a 16-bit word spread over two consecutive codes
// - code 0x00 reads the live board state word
// - state bit 15 set whenever any error summary bit is set
// - state bits 14 and 13 reserved, read zero
// - discharge-complete set when discharge ends at 2800 mV cutoff
// - running discharge shows mode: pulse bit 11, power bit 10, current bit 9
// - charge-complete set on -1 mA cutoff or charger ending the charge
// - charge-active bit 7 set while a charge runs
// - remote-sensor bit set while external sensor attached
// - gauge supply and gauge on bits always read one
// - supply-present bit follows external power detection
// - reference-regulator bit follows precision regulator enable
// - undervoltage set when voltage measurement below 2800 mV
// - no discharge may start while undervoltage is set
// - undervoltage clears itself once voltage rises above 2800 mV
// - cell-linked bit follows closed isolation switches
// - code 0x04 reads the hardware revision word
// - command port reads back the last subcommand written
// - stop subcommand ends operations and clears charge/discharge flags
// ==========================================================================
`timescale 1ns/10ps
`default_nettype none
`include "board_cmd_regs.svh"
module eval_board_command_registers #(
  parameter logic [15:0] HW_REVISION = 16'h0001, // arbitrary value
  parameter logic [15:0] FW_REVISION = 16'h0104
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  // byte access: code phase, then data bytes
  input wire logic code_load_in,
  input wire board_cmd_pkg::code_t code_in,
  input wire logic rd_byte_in,
  input wire logic wr_byte_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  // board measurements and conditions
  input wire board_cmd_pkg::word_t rail_mv_in,
  input wire board_cmd_pkg::word_t rail_ma_in,
  input wire logic meas_valid_in,
  input wire board_cmd_pkg::word_t filt_mv_in,
  input wire board_cmd_pkg::word_t filt_ma_in,
  input wire board_cmd_pkg::word_t onboard_c_in,
  input wire board_cmd_pkg::word_t remote_c_in,
  input wire board_cmd_pkg::word_t errors_in,
  input wire board_cmd_pkg::word_t charger_err_in,
  input wire logic charger_done_in,
  input wire logic remote_sensor_present_in,
  input wire logic supply_present_in,
  input wire logic reference_regulator_on_in,
  // controls toward the load, charger and isolation switches, and a registered copy of the state word
  output logic charge_en_out,
  output logic discharge_en_out,
  output logic [1:0] discharge_mode_out,
  output logic link_close_out,
  output board_cmd_pkg::word_t board_state_out
);
  import board_cmd_pkg::*;

  // ======================================================================
  // code pointer
  code_t ptr;
  logic byte_done;
  assign byte_done = rd_byte_in | wr_byte_in;

  code_pointer u_ptr (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .code_load_in(code_load_in),
    .code_in(code_in),
    .byte_done_in(byte_done),
    .code_out(ptr)
  );

  // ======================================================================
  // operation state
  op_t op;
  op_t next_op;
  dsg_mode_t mode;
  dsg_mode_t next_mode;
  logic chg_term, next_chg_term;
  logic dsg_term, next_dsg_term;
  logic underv, next_underv;
  logic linked, next_linked;
  word_t cmd_port, next_cmd_port;
  logic [7:0] wr_low, next_wr_low;
  logic cmd_strobe;
  word_t cmd_word;

  // a write to the odd code completes the subcommand word
  assign cmd_strobe = wr_byte_in && (ptr == (`CODE_CMD_PORT | 8'h01));
  assign cmd_word = {wr_data_in, wr_low};

  function automatic logic below_cutoff(input word_t mv);
    below_cutoff = mv < `CUTOFF_MV;
  endfunction

  always_comb begin
    next_op = op;
    next_mode = mode;
    next_chg_term = chg_term;
    next_dsg_term = dsg_term;
    next_underv = underv;
    next_linked = linked;
    next_cmd_port = cmd_port;
    next_wr_low = wr_low;
    if (wr_byte_in && ptr == `CODE_CMD_PORT) begin
      next_wr_low = wr_data_in;
    end
    if (meas_valid_in) begin
      if (below_cutoff(rail_mv_in)) begin
        next_underv = 1'b1;
      end else if (rail_mv_in > `CUTOFF_MV) begin
        next_underv = 1'b0;
      end
    end
    // operations end on their cutoffs
    if (op == op_discharge && meas_valid_in && below_cutoff(rail_mv_in)) begin
      next_op = op_idle;
      next_mode = mode_none;
      next_dsg_term = 1'b1;
    end
    if (op == op_charge && ((meas_valid_in && rail_ma_in == `CHG_CUTOFF_MA) || charger_done_in)) begin
      next_op = op_idle;
      next_chg_term = 1'b1;
    end
    if (cmd_strobe) begin
      next_cmd_port = cmd_word;
      unique case (cmd_word)
        `SUB_STOP: begin
          next_op = op_idle;
          next_mode = mode_none;
          next_chg_term = 1'b0;
          next_dsg_term = 1'b0;
        end
        `SUB_CONNECT: next_linked = 1'b1;
        `SUB_DISCONNECT: next_linked = 1'b0;
        `SUB_START_CI, `SUB_START_CP, `SUB_START_PULSE: begin
          // refused outright while the cell sits under the cutoff
          if (!underv) begin
            next_op = op_discharge;
            next_dsg_term = 1'b0;
            next_chg_term = 1'b0;
            next_mode = (cmd_word == `SUB_START_CI) ? mode_ci :
                        (cmd_word == `SUB_START_CP) ? mode_cp : mode_pulse;
          end
        end
        `SUB_START_CHG: begin
          next_op = op_charge;
          next_mode = mode_none;
          next_chg_term = 1'b0;
          next_dsg_term = 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      op <= op_idle;
      mode <= mode_none;
      chg_term <= 1'b0;
      dsg_term <= 1'b0;
      underv <= 1'b0;
      linked <= 1'b0;
      cmd_port <= `CMD_PORT_RESET;
      wr_low <= 8'h00;
    end else begin
      op <= next_op;
      mode <= next_mode;
      chg_term <= next_chg_term;
      dsg_term <= next_dsg_term;
      underv <= next_underv;
      linked <= next_linked;
      cmd_port <= next_cmd_port;
      wr_low <= next_wr_low;
    end
  end

  // ======================================================================
  // state word
  word_t state_word;
  always_comb begin
    state_word = 16'h0000;
    state_word[`BIT_FAULT] = |errors_in;
    state_word[`BIT_DSG_TERM] = dsg_term;
    state_word[`BIT_DSG_PULSE] = (op == op_discharge) && (mode == mode_pulse);
    state_word[`BIT_DSG_CP] = (op == op_discharge) && (mode == mode_cp);
    state_word[`BIT_DSG_CI] = (op == op_discharge) && (mode == mode_ci);
    state_word[`BIT_CHG_TERM] = chg_term;
    state_word[`BIT_CHG] = (op == op_charge);
    state_word[`BIT_REMOTE] = remote_sensor_present_in;
    state_word[`BIT_GAUGE_SUPPLY] = 1'b1;
    state_word[`BIT_GAUGE_ON] = 1'b1;
    state_word[`BIT_SUPPLY] = supply_present_in;
    state_word[`BIT_REFREG] = reference_regulator_on_in;
    state_word[`BIT_UNDERV] = underv;
    state_word[`BIT_LINKED] = linked;
  end

  // ======================================================================
  // read mux
  function automatic word_t word_at(input code_t even, input word_t st);
    unique case (even)
      `CODE_STATE: word_at = st;
      `CODE_HW_REV: word_at = HW_REVISION;
      `CODE_FW_REV: word_at = FW_REVISION;
      `CODE_ERRORS: word_at = errors_in;
      `CODE_RAIL_MV: word_at = rail_mv_in;
      `CODE_RAIL_MA: word_at = rail_ma_in;
      `CODE_FILT_MV: word_at = filt_mv_in;
      `CODE_FILT_MA: word_at = filt_ma_in;
      `CODE_ONBOARD_C: word_at = onboard_c_in;
      `CODE_REMOTE_C: word_at = remote_c_in;
      `CODE_CHG_ERR: word_at = charger_err_in;
      `CODE_CMD_PORT: word_at = cmd_port;
      default: word_at = 16'h0000;
    endcase
  endfunction

  word_t sel_word;
  logic [7:0] next_rd_data;
  logic next_rd_valid;
  // high byte is snapshot with the low byte so a word never tears
  word_t snap, next_snap;
  always_comb begin
    sel_word = word_at({ptr[7:1], 1'b0}, state_word);
    next_rd_data = rd_data_out;
    next_rd_valid = rd_byte_in;
    next_snap = snap;
    if (rd_byte_in) begin
      if (!ptr[0]) begin
        next_rd_data = sel_word[7:0];
        next_snap = sel_word;
      end else begin
        next_rd_data = snap[15:8];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
      snap <= 16'h0000;
      charge_en_out <= 1'b0;
      discharge_en_out <= 1'b0;
      discharge_mode_out <= 2'b00;
      link_close_out <= 1'b0;
      board_state_out <= 16'h0000;
    end else begin
      rd_data_out <= next_rd_data;
      rd_valid_out <= next_rd_valid;
      snap <= next_snap;
      charge_en_out <= (next_op == op_charge);
      discharge_en_out <= (next_op == op_discharge);
      discharge_mode_out <= next_mode;
      link_close_out <= next_linked;
      board_state_out <= state_word;
    end
  end
endmodule
`default_nettype wire

/* tb/cmd_bank_assertions.sv */
// port checks for the command register bank
`timescale 1ns/10ps
`default_nettype none
module cmd_bank_assertions (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic rd_byte_in,
  input wire logic rd_valid_out,
  input wire board_cmd_pkg::word_t errors_in,
  input wire logic remote_sensor_present_in,
  input wire logic supply_present_in,
  input wire logic reference_regulator_on_in,
  input wire logic charge_en_out,
  input wire logic discharge_en_out,
  input wire logic [1:0] discharge_mode_out,
  input wire board_cmd_pkg::word_t board_state_out
);
  import board_cmd_pkg::*;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  // ==========
  // state copy lags a cycle, so flags are held against last cycle's cause
  property p_rd_answer; !reset_in |=> rd_valid_out == $past(rd_byte_in); endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rsvd; board_state_out[14:13] == 2'b00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved state bits set");
  property p_gauge; !$past(reset_in) |-> board_state_out[5:4] == 2'b11; endproperty
  a_gauge: assert property (p_gauge) else $error("gauge bits not one");
  property p_fault; !$past(reset_in) |-> board_state_out[15] == |$past(errors_in); endproperty
  a_fault: assert property (p_fault) else $error("fault bit wrong");
  property p_levels; !$past(reset_in) |-> board_state_out[6] == $past(remote_sensor_present_in)
    && board_state_out[3] == $past(supply_present_in) && board_state_out[2] == $past(reference_regulator_on_in);
  endproperty
  a_levels: assert property (p_levels) else $error("level flags wrong");
  property p_chg; !$past(reset_in) |-> board_state_out[7] == $past(charge_en_out); endproperty
  a_chg: assert property (p_chg) else $error("charge flag wrong");
  property p_mode; !$past(reset_in) |-> board_state_out[11:9] ==
    ($past(discharge_en_out) ? 3'b001 << ($past(discharge_mode_out) - 2'd1) : 3'b000); endproperty
  a_mode: assert property (p_mode) else $error("discharge mode flags wrong");
  property p_nodsg; $rose(discharge_en_out) |-> !board_state_out[1]; endproperty
  a_nodsg: assert property (p_nodsg) else $error("discharge began at low voltage");
endmodule
bind eval_board_command_registers cmd_bank_assertions u_chk (.mclk_in(mclk_in), .reset_in(reset_in),
  .rd_byte_in(rd_byte_in), .rd_valid_out(rd_valid_out), .errors_in(errors_in),
  .remote_sensor_present_in(remote_sensor_present_in), .supply_present_in(supply_present_in),
  .reference_regulator_on_in(reference_regulator_on_in), .charge_en_out(charge_en_out),
  .discharge_en_out(discharge_en_out), .discharge_mode_out(discharge_mode_out), .board_state_out(board_state_out));
`default_nettype wire

/* tb/cmd_host.sv */
// host model: a code transfer, then the two data bytes of a word
`timescale 1ns/10ps
`default_nettype none
module cmd_host (
  input wire logic mclk_in,
  input wire logic rd_valid_in,
  input wire logic [7:0] rd_data_in,
  output var logic ld_out,
  output var board_cmd_pkg::code_t code_out,
  output var logic rd_out,
  output var logic wr_out,
  output var logic [7:0] wd_out
);
  import board_cmd_pkg::*;
  initial begin
    ld_out = 1'b0;
    code_out = 8'h00;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wd_out = 8'h00;
  end
  // ==========
  // released lines show the inverse so stale data never passes for fresh
  task automatic step(input logic l, input logic r, input logic w, input logic [7:0] b);
    @(negedge mclk_in);
    ld_out = l;
    rd_out = r;
    wr_out = w;
    code_out = b;
    wd_out = b;
    @(negedge mclk_in);
    ld_out = 1'b0;
    rd_out = 1'b0;
    wr_out = 1'b0;
    code_out = ~b;
    wd_out = ~b;
  endtask
  task automatic rd_word(input code_t c, output word_t d);
    step(1'b1, 1'b0, 1'b0, c);
    for (int i = 0; i < 2; i++) begin
      step(1'b0, 1'b1, 1'b0, 8'h00);
      d[8*i+:8] = (rd_valid_in === 1'b1) ? rd_data_in : 8'hxx;
    end
  endtask
  task automatic wr_word(input code_t c, input word_t d);
    step(1'b1, 1'b0, 1'b0, c);
    step(1'b0, 1'b0, 1'b1, d[7:0]);
    step(1'b0, 1'b0, 1'b1, d[15:8]);
    repeat (2) @(negedge mclk_in);
  endtask
endmodule
`default_nettype wire

/* tb/eval_board_command_registers_bench.sv */
// self-checking bench for the command register bank
`timescale 1ns/10ps
`default_nettype none
module eval_board_command_registers_bench;
  import board_cmd_pkg::*;
  localparam word_t HW = 16'h5a3c; // arbitrary value
  localparam word_t BASE = 16'h007c;
  localparam code_t CODES [7] = '{8'h0a, 8'h0c, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1a};
  // all levels low, then one level input at a time: remote sensor, supply, regulator
  localparam logic [2:0] LEVELS [4] = '{3'b000, 3'b100, 3'b010, 3'b001};
  localparam word_t LEVEL_WORDS [4] = '{16'h0030, 16'h0070, 16'h0038, 16'h0034};
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic meas_valid = 1'b0;
  logic chg_done = 1'b0;
  word_t errs = 16'h0000;
  logic rs = 1'b1;
  logic sp = 1'b1;
  logic rr = 1'b1;
  word_t v [7] = '{16'h0c1a, 16'h0123, 16'h0b2c, 16'h8001, 16'h0019, 16'h001e, 16'h00a5};
  logic ld, rb, wb, rv, ce, de, lk;
  code_t cd;
  logic [7:0] wd, rdt;
  logic [1:0] dm;
  word_t st, w;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  always #50 mclk_in = ~mclk_in;
  cmd_host host (.mclk_in(mclk_in), .rd_valid_in(rv), .rd_data_in(rdt), .ld_out(ld), .code_out(cd),
    .rd_out(rb), .wr_out(wb), .wd_out(wd));
  eval_board_command_registers #(.HW_REVISION(HW)) dut (.mclk_in(mclk_in), .reset_in(reset_in),
    .code_load_in(ld), .code_in(cd), .rd_byte_in(rb), .wr_byte_in(wb), .wr_data_in(wd), .rd_data_out(rdt),
    .rd_valid_out(rv), .rail_mv_in(v[0]), .rail_ma_in(v[1]), .meas_valid_in(meas_valid), .filt_mv_in(v[2]),
    .filt_ma_in(v[3]), .onboard_c_in(v[4]), .remote_c_in(v[5]), .errors_in(errs), .charger_err_in(v[6]),
    .charger_done_in(chg_done), .remote_sensor_present_in(rs), .supply_present_in(sp),
    .reference_regulator_on_in(rr), .charge_en_out(ce), .discharge_en_out(de), .discharge_mode_out(dm),
    .link_close_out(lk), .board_state_out(st));
  // ==========
  task automatic chk(input string n, input word_t e, input word_t g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input code_t c, input word_t e);
    host.rd_word(c, w);
    chk($sformatf("code %h", c), e, w);
  endtask
  task automatic wr(input word_t s);
    host.wr_word(8'h1c, s);
  endtask
  task automatic meas(input word_t mv, input word_t ma);
    @(negedge mclk_in);
    v[0] = mv;
    v[1] = ma;
    meas_valid = 1'b1;
    @(negedge mclk_in);
    meas_valid = 1'b0;
    repeat (3) @(negedge mclk_in);
  endtask
  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 4000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge mclk_in);
    @(negedge mclk_in);
    reset_in = 1'b0;
    rd(8'h00, BASE);
    chk("state out", BASE, st);
    rd(8'h04, HW);
    rd(8'h06, 16'h0104);
    rd(8'h02, 16'h0000);
    for (int i = 0; i < 7; i++) rd(CODES[i], v[i]);
    // each level flag alone, so swapped bits cannot hide
    for (int k = 0; k < 4; k++) begin
      {rs, sp, rr} = LEVELS[k];
      rd(8'h00, LEVEL_WORDS[k]);
      chk("state out", LEVEL_WORDS[k], st);
    end
    {rs, sp, rr} = 3'b111;
    errs = 16'h0004;
    rd(8'h08, 16'h0004);
    rd(8'h00, BASE | 16'h8000);
    chk("state out", BASE | 16'h8000, st);
    errs = 16'h0000;
    wr(16'h0001);
    chk("link", 16'h0001, {15'h0, lk});
    rd(8'h1c, 16'h0001);
    // writes away from the command port are ignored
    host.wr_word(8'h04, 16'hffff);
    rd(8'h04, HW);
    for (int i = 0; i < 3; i++) begin
      wr(word_t'(5 + i));
      chk("mode", word_t'(5 + i), {13'h0, de, dm});
      rd(8'h00, word_t'(BASE | 16'h0001 | (16'h0200 << i)));
      wr(16'h0000);
      rd(8'h00, BASE | 16'h0001);
    end
    // unknown subcommand is kept for read-back but does nothing
    wr(16'h001a);
    rd(8'h1c, 16'h001a);
    rd(8'h00, BASE | 16'h0001);
    // below cutoff mid-discharge: ends it, then blocks a new start
    wr(16'h0005);
    meas(16'h0aef, 16'h0123);
    chk("discharge", 16'h0000, {15'h0, de});
    rd(8'h00, BASE | 16'h1003);
    chk("state out", BASE | 16'h1003, st);
    wr(16'h0005);
    chk("discharge", 16'h0000, {15'h0, de});
    meas(16'h0af1, 16'h0123);
    host.rd_word(8'h00, w);
    chk("low voltage", 16'h0000, w & 16'h0002);
    wr(16'h0000);
    wr(16'h0008);
    chk("charge", 16'h0001, {15'h0, ce});
    rd(8'h00, BASE | 16'h0081);
    meas(16'h0c1a, 16'hffff);
    chk("charge", 16'h0000, {15'h0, ce});
    rd(8'h00, BASE | 16'h0101);
    wr(16'h0008);
    @(negedge mclk_in);
    chg_done = 1'b1;
    @(negedge mclk_in);
    chg_done = 1'b0;
    repeat (3) @(negedge mclk_in);
    rd(8'h00, BASE | 16'h0101);
    wr(16'h0000);
    rd(8'h00, BASE | 16'h0001);
    // reset in mid-run while a discharge runs and the cell is linked
    wr(16'h0006);
    chk("mode", 16'h0006, {13'h0, de, dm});
    @(negedge mclk_in);
    reset_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    reset_in = 1'b0;
    chk("outputs after reset", 16'h0000, {11'h0, ce, de, lk, dm});
    rd(8'h00, BASE);
    rd(8'h1c, 16'h0000);
    wr(16'h0001);
    chk("link", 16'h0001, {15'h0, lk});
    wr(16'h0002);
    chk("link", 16'h0000, {15'h0, lk});
    stop_test();
  end
endmodule
`default_nettype wire
